/* File: logic/lsp_cfg.svh */
`ifndef LSP_CFG_SVH
`define LSP_CFG_SVH

`define LSP_WORD_BITS 16
`define LSP_FRAME_BITS 128
`define LSP_LANES 8
`define LSP_CONVS 16
`define LSP_SLOTS 8
`define LSP_MIN_BITS 5'd10
`define LSP_PAIR_LIMIT 5'd12
`define LSP_NP_SHORT 5'd12
`define LSP_NP_LONG 5'd16
`define LSP_OCTET_SHIFT 3
`define LSP_CTRL_WORDS 4'd0
`define LSP_CNT_8 4'd8
`define LSP_CNT_4 4'd4
`define LSP_CNT_2 4'd2
`define LSP_LANES_8 4'd8
`define LSP_LANES_4 4'd4
`define LSP_LANES_2 4'd2
`define LSP_RST_CPL 2'h1
`define LSP_RST_WIDTH 2'h1
`define LSP_RST_RES 2'h1

`endif

/* File: logic/lsp_pkg.sv */
package lsp_pkg;
   typedef enum logic [1:0] {
      LSP_CPL_8 = 2'b00,
      LSP_CPL_4 = 2'b01,
      LSP_CPL_2 = 2'b10
   } lsp_cpl_t;
   typedef enum logic [1:0] {
      LSP_BITS_10 = 2'b00,
      LSP_BITS_12 = 2'b01,
      LSP_BITS_14 = 2'b10,
      LSP_BITS_16 = 2'b11
   } lsp_bits_t;
endpackage

/* File: logic/lsp_lane_pack.sv */
`timescale 1ns/100ps
`include "lsp_cfg.svh"
module lsp_lane_pack #(
   parameter int WORD = `LSP_WORD_BITS,
   parameter int SLOTS = `LSP_SLOTS,
   parameter int FRAME = `LSP_FRAME_BITS
) (
   input wire logic [SLOTS*WORD-1:0] words,
   input wire logic [4:0] n_bits,
   input wire logic [3:0] count,
   output logic [FRAME-1:0] frame
);
   logic [FRAME-1:0] acc;
   int total;

   // each of the first count slots gives its top n_bits, packed back to back msb first
   always_comb begin
      acc = '0;
      total = 0;
      for (int i = 0; i < SLOTS; i++) begin
         if (i < int'(count)) begin
            acc = (acc << n_bits) |
               FRAME'(words[i*WORD +: WORD] >> (WORD - int'(n_bits)));
            total = total + int'(n_bits);
         end
      end
      // left-align so octet 1 sits at the top, rest is zero tail
      frame = acc << (FRAME - total);
   end
endmodule // lsp_lane_pack

/* File: logic/lsp_lane_sample_packer.sv */
// Function
// - converters per lane is eight, four or two
// - lane count follows from converters per lane
// - unneeded lanes disabled automatically
// - no control words, control count zero
// - two packing modes by one control
// - packer derives bits per sample and octets
// - eight/four per lane: N' is width
// - two per lane: N' 12 or 16
// - pad sample with low zeros to width
// - dense nibble packing, no gaps
// - octet-pair mode: sixteen bits per sample
// - ascending converter order, msb first
// - all lanes use lane one's arrangement
// - converter index maps to matching input
// - lane k carries converters from 2k-1
// - one sample per converter per frame
`timescale 1ns/100ps
`include "lsp_cfg.svh"
module lsp_lane_sample_packer
   import lsp_pkg::*;
#(
   parameter int LANES = `LSP_LANES,
   parameter int CONVS = `LSP_CONVS,
   parameter int WORD = `LSP_WORD_BITS,
   parameter int SLOTS = `LSP_SLOTS,
   parameter int FRAME = `LSP_FRAME_BITS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [1:0] lane_converter_count,
   input wire logic [1:0] serial_word_width,
   input wire logic [1:0] conversion_resolution,
   input wire logic octet_pair_mode_select,
   input wire logic sample_valid,
   input wire logic [WORD-1:0] transmitter_sample_input [CONVS],
   output logic frame_valid,
   output logic [FRAME-1:0] lane_frame [LANES],
   output logic [LANES-1:0] lane_enable,
   output logic [3:0] lane_count,
   output logic [4:0] sample_bits,
   output logic [4:0] frame_octets,
   output logic [3:0] control_words
);
   function automatic logic [4:0] bits_of(input logic [1:0] code);
      bits_of = `LSP_MIN_BITS + 5'({code, 1'b0});
   endfunction

   function automatic logic [3:0] per_lane(input logic [1:0] code);
      case (code)
         LSP_CPL_8: per_lane = `LSP_CNT_8;
         LSP_CPL_4: per_lane = `LSP_CNT_4;
         default: per_lane = `LSP_CNT_2;
      endcase
   endfunction

   logic [1:0] cpl;
   logic [1:0] width_code;
   logic [1:0] res_code;
   logic octet_mode;
   wire cpl_legal;

   // an illegal converters-per-lane code is ignored, old setting kept
   assign cpl_legal = lane_converter_count == LSP_CPL_8 ||
      lane_converter_count == LSP_CPL_4 ||
      lane_converter_count == LSP_CPL_2;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cpl <= `LSP_RST_CPL;
         width_code <= `LSP_RST_WIDTH;
         res_code <= `LSP_RST_RES;
         octet_mode <= 1'b0;
      end else begin
         if (cpl_legal) begin
            cpl <= lane_converter_count;
         end
         width_code <= serial_word_width;
         res_code <= conversion_resolution;
         octet_mode <= octet_pair_mode_select;
      end
   end

   wire [4:0] width_bits;
   wire [4:0] res_bits;
   wire [3:0] conv_per_lane;
   wire [4:0] np_pair;
   wire [4:0] np_normal;
   wire [4:0] next_np;
   wire [8:0] frame_bit_count;

   assign width_bits = bits_of(width_code);
   assign res_bits = bits_of(res_code);
   assign conv_per_lane = per_lane(cpl);
   assign np_pair = (width_bits <= `LSP_PAIR_LIMIT) ?
      `LSP_NP_SHORT : `LSP_NP_LONG;
   assign np_normal = (cpl == LSP_CPL_2) ? np_pair : width_bits;
   assign next_np = octet_mode ? `LSP_NP_LONG : np_normal;
   // operands widened first so the product cannot wrap
   assign frame_bit_count = 9'(conv_per_lane) * 9'(next_np);
   assign sample_bits = next_np;
   assign frame_octets = 5'(frame_bit_count >> `LSP_OCTET_SHIFT);
   assign control_words = `LSP_CTRL_WORDS;
   assign lane_count = (cpl == LSP_CPL_8) ? `LSP_LANES_2 :
      (cpl == LSP_CPL_4) ? `LSP_LANES_4 : `LSP_LANES_8;

   // resolution mask and left alignment; low bits stay zero as padding
   wire [WORD-1:0] res_mask;
   wire [4:0] align_shift;
   wire [WORD-1:0] prep [CONVS];

   assign res_mask = {WORD{1'b1}} >> (5'(WORD) - res_bits);
   // width below resolution is a software fault; top bits still win
   assign align_shift = 5'(WORD) - res_bits;

   genvar gi;
   generate
      for (gi = 0; gi < CONVS; gi++) begin : g_prep
         assign prep[gi] = (transmitter_sample_input[gi] & res_mask) <<
            align_shift;
      end
   endgenerate

   // lane l starts at converter 2l; active when l is a multiple of cpl/2
   genvar gl, gs;
   generate
      for (gl = 0; gl < LANES; gl++) begin : g_lane
         logic [SLOTS*WORD-1:0] slot_words;
         logic [FRAME-1:0] packed_frame;
         wire active;

         assign active = (cpl == LSP_CPL_2) ||
            (cpl == LSP_CPL_4 && (gl % 2) == 0) ||
            (cpl == LSP_CPL_8 && (gl % 4) == 0);
         assign lane_enable[gl] = active;

         for (gs = 0; gs < SLOTS; gs++) begin : g_slot
            if (2 * gl + gs < CONVS) begin : g_map
               assign slot_words[gs*WORD +: WORD] = prep[2*gl+gs];
            end else begin : g_none
               assign slot_words[gs*WORD +: WORD] = '0;
            end
         end

         lsp_lane_pack #(
            .WORD(WORD),
            .SLOTS(SLOTS),
            .FRAME(FRAME)
         ) u_pack (
            .words(slot_words),
            .n_bits(next_np),
            .count(conv_per_lane),
            .frame(packed_frame)
         );

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               lane_frame[gl] <= '0;
            end else if (sample_valid) begin
               lane_frame[gl] <= active ? packed_frame : '0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frame_valid <= 1'b0;
      end else begin
         frame_valid <= sample_valid;
      end
   end

   // checks

   property p_ctrl_zero;
      @(posedge clk) disable iff (rst)
         control_words == 4'h0;
   endproperty
   a_ctrl_zero: assert property (p_ctrl_zero)
      else $error("control word count not zero");

   property p_lane_cnt;
      @(posedge clk) disable iff (rst)
         lane_count * conv_per_lane == 8'h10 &&
         $countones(lane_enable) == int'(lane_count);
   endproperty
   a_lane_cnt: assert property (p_lane_cnt)
      else $error("lane count does not match converters per lane");

   property p_illegal_hold;
      @(posedge clk) disable iff (rst)
         lane_converter_count == 2'h3 |=> $stable(cpl);
   endproperty
   a_illegal_hold: assert property (p_illegal_hold)
      else $error("illegal converters per lane code was taken");

   property p_np_pair;
      @(posedge clk) disable iff (rst)
         (cpl == LSP_CPL_2 && !octet_mode) |->
         (width_bits <= 5'hc ? (sample_bits == 5'hc && frame_octets == 5'h3)
                             : (sample_bits == 5'h10 && frame_octets == 5'h4));
   endproperty
   a_np_pair: assert property (p_np_pair)
      else $error("two per lane sizes wrong");

   property p_np_normal;
      @(posedge clk) disable iff (rst)
         (cpl != LSP_CPL_2 && !octet_mode) |->
         sample_bits == width_bits &&
         frame_octets == (cpl == LSP_CPL_8 ? width_bits : width_bits >> 1);
   endproperty
   a_np_normal: assert property (p_np_normal)
      else $error("normal packing sizes wrong");

   property p_octet_mode;
      @(posedge clk) disable iff (rst)
         octet_mode |-> sample_bits == 5'h10 &&
         frame_octets == {conv_per_lane, 1'b0};
   endproperty
   a_octet_mode: assert property (p_octet_mode)
      else $error("octet pair sizes wrong");

   property p_frame_timing;
      @(posedge clk) disable iff (rst)
         sample_valid |=> frame_valid ##1 (frame_valid == $past(sample_valid));
   endproperty
   a_frame_timing: assert property (p_frame_timing)
      else $error("frame not emitted one cycle after samples");

   property p_first_nibble;
      @(posedge clk) disable iff (rst)
         sample_valid |=>
         lane_frame[0][FRAME-1 -: 4] == $past(prep[0][WORD-1 -: 4]);
   endproperty
   a_first_nibble: assert property (p_first_nibble)
      else $error("first octet does not lead with converter one");

   property p_tail_zero;
      @(posedge clk) disable iff (rst)
         sample_valid |=>
         (lane_frame[0] << {$past(frame_octets), 3'b000}) == '0;
   endproperty
   a_tail_zero: assert property (p_tail_zero)
      else $error("bits beyond frame length not zero");

   property p_idle_lane;
      @(posedge clk) disable iff (rst)
         (sample_valid && !lane_enable[1]) |=> lane_frame[1] == '0;
   endproperty
   a_idle_lane: assert property (p_idle_lane)
      else $error("disabled lane carries data");

   property p_pad_low;
      @(posedge clk) disable iff (rst)
         (sample_valid && res_bits < 5'h10) |->
         (prep[0] & ~({WORD{1'b1}} << (5'h10 - res_bits))) == '0;
   endproperty
   a_pad_low: assert property (p_pad_low)
      else $error("padding bits not zero");

   property p_frame_hold;
      @(posedge clk) disable iff (rst)
         !sample_valid |=> $stable(lane_frame[0]) && $stable(lane_frame[7]);
   endproperty
   a_frame_hold: assert property (p_frame_hold)
      else $error("lane frame changed without new samples");

   property p_upper_group;
      @(posedge clk) disable iff (rst)
         sample_valid |=>
         lane_frame[4][FRAME-1 -: 4] == $past(prep[8][WORD-1 -: 4]);
   endproperty
   a_upper_group: assert property (p_upper_group)
      else $error("fifth lane does not lead with converter nine");

   property p_octet_split;
      @(posedge clk) disable iff (rst)
         (sample_valid && octet_mode) |=>
         lane_frame[0][FRAME-1-WORD -: WORD] == $past(prep[1]);
   endproperty
   a_octet_split: assert property (p_octet_split)
      else $error("second sample does not fill octets three and four");

   property p_enable_pattern;
      @(posedge clk) disable iff (rst)
         lane_enable[0] && (lane_enable[7] == (cpl == LSP_CPL_2)) &&
         (lane_enable[2] == (cpl != LSP_CPL_8));
   endproperty
   a_enable_pattern: assert property (p_enable_pattern)
      else $error("lane enable pattern does not match converters per lane");

   c_cpl8: cover property (@(posedge clk) disable iff (rst)
      cpl == LSP_CPL_8 && sample_valid ##1 frame_valid);
   c_cpl2: cover property (@(posedge clk) disable iff (rst)
      cpl == LSP_CPL_2 && sample_valid ##1 frame_valid);
   c_octet: cover property (@(posedge clk) disable iff (rst)
      octet_mode && sample_valid ##1 frame_valid);
   c_pad: cover property (@(posedge clk) disable iff (rst)
      width_bits > res_bits && sample_valid);
   c_cpl4: cover property (@(posedge clk) disable iff (rst)
      cpl == LSP_CPL_4 && sample_valid ##1 frame_valid);
endmodule // lsp_lane_sample_packer

/* File: verification/lsp_link_model.sv */
`timescale 1ns/100ps
module lsp_link_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic frame_valid,
   input wire logic [127:0] lane_frame [8],
   output logic [127:0] rx_frame [8],
   output int rx_count
);
   // takes every lane raw, so a lane that should be idle is still seen
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_count <= 0;
         rx_frame <= '{default: '0};
      end else if (frame_valid) begin
         rx_count <= rx_count + 1;
         rx_frame <= lane_frame;
      end
   end
endmodule // lsp_link_model

/* File: verification/tb.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin \
   num_checks++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end
module tb;
   import lsp_pkg::*;
   logic clk, rst, octet_pair_mode_select, sample_valid, frame_valid;
   logic [1:0] lane_converter_count, serial_word_width, conversion_resolution;
   logic [15:0] smp [16];
   logic [127:0] lane_frame [8];
   logic [127:0] rx_frame [8];
   logic [127:0] ea;
   logic [7:0] lane_enable, en;
   logic [3:0] lane_count, control_words;
   logic [4:0] sample_bits, frame_octets;
   int rx_count, n_errors, num_checks, n_frames;

   lsp_lane_sample_packer lsp_lane_sample_packer_i (.clk(clk), .rst(rst),
      .lane_converter_count(lane_converter_count),
      .serial_word_width(serial_word_width),
      .conversion_resolution(conversion_resolution),
      .octet_pair_mode_select(octet_pair_mode_select),
      .sample_valid(sample_valid), .transmitter_sample_input(smp),
      .frame_valid(frame_valid), .lane_frame(lane_frame),
      .lane_enable(lane_enable), .lane_count(lane_count),
      .sample_bits(sample_bits), .frame_octets(frame_octets),
      .control_words(control_words));
   lsp_link_model lsp_link_model_i (.clk(clk), .rst(rst),
      .frame_valid(frame_valid), .lane_frame(lane_frame),
      .rx_frame(rx_frame), .rx_count(rx_count));

   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end

   task automatic step;
      @(posedge clk);
      #1;
   endtask

   task automatic cfg(int c, int w, int r, bit m);
      lane_converter_count = 2'(c);
      serial_word_width = 2'(w);
      conversion_resolution = 2'(r);
      octet_pair_mode_select = m;
      step();
   endtask

   function automatic int np_of(int cpl, int w, bit m);
      return m ? 16 : (cpl == 2 ? (w <= 12 ? 12 : 16) : w);
   endfunction

   function automatic logic [127:0] exp_frame(int l, int cpl, int w, int r,
                                              bit m);
      logic [127:0] f;
      logic [15:0] a;
      int pos;
      f = '0;
      pos = 127;
      if (l % (cpl / 2) != 0) return f;
      for (int j = 0; j < cpl; j++) begin
         // drop bits above resolution, left-align, then keep top bits
         a = smp[2 * l + j] << (16 - r);
         for (int b = 15; b > 15 - np_of(cpl, w, m); b--) begin
            f[pos] = a[b];
            pos--;
         end
      end
      return f;
   endfunction

   task automatic load(int base);
      for (int i = 0; i < 16; i++) smp[i] = 16'((i + 1) * 16'h1357 + base);
   endtask

   task automatic send(int c, int w, int r, bit m, int base);
      int cpl;
      cpl = 8 >> c;
      load(base);
      sample_valid = 1;
      step();
      sample_valid = 0;
      n_frames++;
      `CHK(frame_valid, 1'b1)
      for (int l = 0; l < 8; l++) begin
         ea = exp_frame(l, cpl, 10 + 2 * w, 10 + 2 * r, m);
         `CHK(lane_frame[l], ea)
      end
   endtask

   task automatic t_sweep;
      int cpl, wb, fo;
      for (int c = 0; c < 3; c++) for (int w = 0; w < 4; w++)
         for (int r = 0; r <= w; r++) for (int m = 0; m < 2; m++) begin
            cpl = 8 >> c;
            wb = 10 + 2 * w;
            fo = m ? 2 * cpl : (cpl == 2 ? np_of(2, wb, 0) / 4 : wb * cpl / 8);
            for (int l = 0; l < 8; l++) en[l] = (l % (cpl / 2) == 0);
            cfg(c, w, r, m[0]);
            `CHK(lane_count, 4'(16 / cpl))
            `CHK(lane_enable, en)
            `CHK(sample_bits, 5'(np_of(cpl, wb, m[0])))
            `CHK(frame_octets, 5'(fo))
            `CHK(control_words, 4'h0)
            send(c, w, r, m[0], c * 64 + w * 16 + r * 4 + m);
         end
      $display("test sweep done");
   endtask

   task automatic t_b2b;
      cfg(2, 3, 3, 0);
      load(16'h0a5c);
      ea = exp_frame(0, 2, 16, 16, 0);
      sample_valid = 1;
      step();
      load(16'h7e01);
      step();
      sample_valid = 0;
      n_frames += 2;
      `CHK(frame_valid, 1'b1)
      `CHK(rx_frame[0], ea)
      `CHK(lane_frame[7], exp_frame(7, 2, 16, 16, 0))
      step();
      `CHK(frame_valid, 1'b0)
      `CHK(lane_frame[7], exp_frame(7, 2, 16, 16, 0))
      $display("test back to back done");
   endtask

   task automatic t_refused;
      cfg(1, 1, 0, 0);
      cfg(3, 1, 0, 0);
      `CHK(lane_count, 4'h4)
      send(1, 1, 0, 0, 16'h0321);
      `CHK(rx_count, n_frames - 1)
      step();
      `CHK(rx_count, n_frames)
      $display("test refused code done");
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #250_000;
      n_errors++;
      $display("run exceeded its time limit");
      finish_test();
   end

   initial begin
      rst = 1;
      sample_valid = 0;
      n_frames = 0;
      load(0);
      lane_converter_count = 2'h0;
      serial_word_width = 2'h3;
      conversion_resolution = 2'h3;
      octet_pair_mode_select = 1;
      step();
      `CHK(lane_enable, 8'h55)
      `CHK(lane_count, 4'h4)
      `CHK(sample_bits, 5'h0c)
      `CHK(frame_octets, 5'h06)
      `CHK(frame_valid, 1'b0)
      step();
      rst = 0;
      $display("test reset done");
      t_sweep();
      t_b2b();
      t_refused();
      finish_test();
   end
endmodule // tb
